// *** hw/pst_phase_stepper.sv ***
// Purpose: phase-accumulating frequency generator with byte register port
// Assumes: all inputs synchronous to clk_sys; source clocks are sampled levels
// Notes:   module clock edges are detected on clk_sys, so sources must run
//          well below half of clk_sys
//
// What this block does
// RULE1 - oscillator runs only while enable bit 7 is set
// RULE2 - control bit 5 is read-only and shows the present output level
// RULE3 - invert_select bit 4 inverts the output when set
// RULE4 - pulse mode: output frequency equals the overflow rate
// RULE5 - fixed duty mode: output frequency is half the overflow rate
// RULE6 - pulse width is two to the code module clocks, 1 to 128
// RULE7 - pulse width matters only in pulse mode
// RULE8 - source_select bits 3:0 choose module clock; code 1111 reserved
// RULE9 - accumulator is 20 bits in a 24-bit space, top bits reserved
// RULE10 - accumulator reached as low, high and upper byte registers
// RULE11 - accumulator updates freely; multi-byte reads are not atomic
// RULE12 - software must not write the accumulator while running
// RULE13 - step_value is 20 bits added to accumulator every module clock
// RULE14 - step_value reached as upper, high and low byte registers
// RULE15 - step_shadow loads on module clock falling edge after low byte write
// RULE16 - software writes upper and high step bytes before the low byte
// RULE17 - each module clock rise adds step_shadow; carry from bit 19 overflows
// RULE18 - fixed duty mode toggles the output on every overflow
// RULE19 - pulse mode goes active on the clock after overflow for the width
// RULE20 - overflow sets a sticky flag that software clears
// RULE21 - while disabled accumulator holds and output rests inactive
//
// Chosen here: the address-and-strobe port.
`timescale 1ns/10ps
module pst_phase_stepper (
   input  wire logic                        clk_sys,
   input  wire logic                        reset,
   input  wire pst_pkg::pst_bus_req_t       bus_req,
   output logic [7:0]                       rdata,
   input  wire logic [pst_pkg::PST_NSRC-1:0] src_clk,
   output logic                             stepper_out,
   output logic                             overflow_flag
);
   // picks the level of the source named by a code (codes 1..14)
   function automatic logic src_level(input logic [13:0] vec,
                                      input logic [3:0]  code);
      logic res;
      res = 1'b0;
      if (code != pst_pkg::PST_SRC_SYS && code != pst_pkg::PST_SRC_RSVD) begin
         res = vec[code - 4'h1];
      end
      return res;
   endfunction

   function automatic logic [7:0] byte_of(input logic [19:0] w,
                                          input logic [1:0]  idx);
      logic [23:0] wide;
      wide = {4'h0, w};
      return wide[idx*8 +: 8];
   endfunction

   pst_pkg::pst_ctrl_t       ctrl_q;
   pst_pkg::pst_clksel_t     clksel_q;
   pst_pkg::pst_load_state_t load_q;
   logic [19:0]              step_q;
   logic [19:0]              shadow_q;
   logic [19:0]              sum_q;
   logic [13:0]              src_q;
   logic                     toggle_q;
   logic                     arm_q;
   logic [7:0]               pcnt_q;
   logic                     out_q;
   logic                     flag_q;
   logic [7:0]               rdata_q;
   logic                     tick;
   logic                     fall;
   logic                     carry;
   logic [20:0]              sum_wide;
   logic                     raw_out;
   logic [7:0]               width_cnt;
   logic [7:0]               rd_mux;
   logic                     wr_sum_l, wr_sum_h, wr_sum_u;
   logic                     wr_step_l;
   logic [2:0]               wr_step;

   always_comb begin
      wr_sum_l  = bus_req.wr && bus_req.addr == pst_pkg::PST_ADDR_SUM_LOW;
      wr_sum_h  = bus_req.wr && bus_req.addr == pst_pkg::PST_ADDR_SUM_HIGH;
      wr_sum_u  = bus_req.wr && bus_req.addr == pst_pkg::PST_ADDR_SUM_UPPER;
      wr_step[0] = bus_req.wr && bus_req.addr == pst_pkg::PST_ADDR_STEP_LOW;
      wr_step[1] = bus_req.wr && bus_req.addr == pst_pkg::PST_ADDR_STEP_HIGH;
      wr_step[2] = bus_req.wr && bus_req.addr == pst_pkg::PST_ADDR_STEP_UPPER;
      wr_step_l = wr_step[0];
   end

   // module clock edges; the system code runs every clk_sys cycle
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         src_q <= '0;
      end else begin
         src_q <= src_clk;
      end
   end

   always_comb begin
      if (clksel_q.source_select == pst_pkg::PST_SRC_SYS) begin
         tick = 1'b1;
         fall = 1'b1;
      end else begin
         // reserved code yields no edges at all  // see RULE8
         tick = src_level(src_clk, clksel_q.source_select) &
                ~src_level(src_q, clksel_q.source_select);
         fall = ~src_level(src_clk, clksel_q.source_select) &
                src_level(src_q, clksel_q.source_select);
      end
   end

   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         ctrl_q <= '0;
      end else if (bus_req.wr && bus_req.addr == pst_pkg::PST_ADDR_CONTROL) begin
         ctrl_q.enable            <= bus_req.wdata[pst_pkg::PST_CON_EN];  // see RULE1
         ctrl_q.invert_select     <= bus_req.wdata[pst_pkg::PST_CON_POL];
         ctrl_q.pulse_mode_select <= bus_req.wdata[pst_pkg::PST_CON_PFM];
      end
   end

   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         clksel_q <= '0;
      end else if (bus_req.wr && bus_req.addr == pst_pkg::PST_ADDR_CLOCK) begin
         clksel_q.pulse_width_select <= bus_req.wdata[pst_pkg::PST_CLK_PWS_LO +: 3];
         clksel_q.source_select      <= bus_req.wdata[pst_pkg::PST_CLK_CKS_LO +: 4];
      end
   end

   // step byte lanes; upper lane keeps only bits 19:16  // see RULE14
   genvar gi;
   generate
      for (gi = 0; gi < 3; gi++) begin : g_step_lane
         localparam int unsigned LW = (gi == 2) ? 4 : 8;
         always_ff @(posedge clk_sys or posedge reset) begin
            if (reset) begin
               step_q[gi*8 +: LW] <= pst_pkg::PST_STEP_RESET[gi*8 +: LW];
            end else if (wr_step[gi]) begin
               step_q[gi*8 +: LW] <= bus_req.wdata[LW-1:0];
            end
         end
      end
   endgenerate

   // shadow load waits for a falling module edge while running,
   // and is taken at once while stopped
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         load_q   <= pst_pkg::PST_LOAD_IDLE;
         shadow_q <= pst_pkg::PST_STEP_RESET;
      end else begin
         case (load_q)
            pst_pkg::PST_LOAD_IDLE: begin
               if (wr_step_l) begin
                  load_q <= pst_pkg::PST_LOAD_WAIT;
               end
            end
            pst_pkg::PST_LOAD_WAIT: begin
               if (!ctrl_q.enable || fall) begin
                  shadow_q <= step_q;  // see RULE15
                  load_q   <= wr_step_l ? pst_pkg::PST_LOAD_WAIT
                                        : pst_pkg::PST_LOAD_IDLE;
               end
            end
            default: begin
               load_q <= pst_pkg::PST_LOAD_IDLE;
            end
         endcase
      end
   end

   assign sum_wide = {1'b0, sum_q} + {1'b0, shadow_q};  // see RULE13
   assign carry    = ctrl_q.enable & tick & sum_wide[20];  // see RULE17

   // a software write wins over an addition in the same cycle
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         sum_q <= pst_pkg::PST_SUM_RESET;
      end else if (wr_sum_l | wr_sum_h | wr_sum_u) begin
         if (wr_sum_l) sum_q[7:0]   <= bus_req.wdata;  // see RULE10
         if (wr_sum_h) sum_q[15:8]  <= bus_req.wdata;
         if (wr_sum_u) sum_q[19:16] <= bus_req.wdata[3:0];  // see RULE9
      end else if (ctrl_q.enable && tick) begin
         sum_q <= sum_wide[19:0];  // see RULE11
      end
   end

   assign width_cnt = pst_pkg::PST_CNT_ONE << clksel_q.pulse_width_select;  // see RULE6

   // fixed duty toggle and pulse counter; both cleared while stopped
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         toggle_q <= 1'b0;
         arm_q    <= 1'b0;
         pcnt_q   <= '0;
      end else if (!ctrl_q.enable) begin
         toggle_q <= 1'b0;  // see RULE21
         arm_q    <= 1'b0;
         pcnt_q   <= '0;
      end else if (tick) begin
         if (carry) begin
            toggle_q <= ~toggle_q;  // see RULE18
         end
         arm_q <= carry;
         if (arm_q) begin
            pcnt_q <= width_cnt;  // see RULE19
         end else if (pcnt_q != pst_pkg::PST_BYTE_ZERO) begin
            pcnt_q <= pcnt_q - 8'h01;
         end
      end
   end

   always_comb begin
      if (ctrl_q.pulse_mode_select) begin
         raw_out = pcnt_q != pst_pkg::PST_BYTE_ZERO;  // see RULE4 RULE7
      end else begin
         raw_out = toggle_q;  // see RULE5
      end
   end

   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         out_q <= 1'b0;
      end else begin
         out_q <= (ctrl_q.enable & raw_out) ^ ctrl_q.invert_select;  // see RULE3
      end
   end

   // set beats a clear in the same cycle
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         flag_q <= 1'b0;
      end else if (carry) begin
         flag_q <= 1'b1;  // see RULE20
      end else if (bus_req.wr && bus_req.addr == pst_pkg::PST_ADDR_FLAG &&
                   bus_req.wdata[pst_pkg::PST_FLAG_BIT]) begin
         flag_q <= 1'b0;
      end
   end

   always_comb begin
      rd_mux = pst_pkg::PST_BYTE_ZERO;
      case (bus_req.addr)
         pst_pkg::PST_ADDR_SUM_LOW:    rd_mux = byte_of(sum_q, 2'd0);
         pst_pkg::PST_ADDR_SUM_HIGH:   rd_mux = byte_of(sum_q, 2'd1);
         pst_pkg::PST_ADDR_SUM_UPPER:  rd_mux = byte_of(sum_q, 2'd2);
         pst_pkg::PST_ADDR_STEP_LOW:   rd_mux = byte_of(step_q, 2'd0);
         pst_pkg::PST_ADDR_STEP_HIGH:  rd_mux = byte_of(step_q, 2'd1);
         pst_pkg::PST_ADDR_STEP_UPPER: rd_mux = byte_of(step_q, 2'd2);
         pst_pkg::PST_ADDR_CONTROL: begin
            rd_mux[pst_pkg::PST_CON_EN]  = ctrl_q.enable;
            rd_mux[pst_pkg::PST_CON_OUT] = out_q;  // see RULE2
            rd_mux[pst_pkg::PST_CON_POL] = ctrl_q.invert_select;
            rd_mux[pst_pkg::PST_CON_PFM] = ctrl_q.pulse_mode_select;
         end
         pst_pkg::PST_ADDR_CLOCK: begin
            rd_mux[pst_pkg::PST_CLK_PWS_LO +: 3] = clksel_q.pulse_width_select;
            rd_mux[pst_pkg::PST_CLK_CKS_LO +: 4] = clksel_q.source_select;
         end
         pst_pkg::PST_ADDR_FLAG: rd_mux[pst_pkg::PST_FLAG_BIT] = flag_q;
         default: rd_mux = pst_pkg::PST_BYTE_ZERO;
      endcase
   end

   // read data stand only in the cycle after the strobe
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         rdata_q <= '0;
      end else begin
         rdata_q <= bus_req.rd ? rd_mux : pst_pkg::PST_BYTE_ZERO;
      end
   end

   assign rdata         = rdata_q;
   assign stepper_out   = out_q;
   assign overflow_flag = flag_q;

   chk_stop_holds_sum: assert property (  // see RULE21
      @(posedge clk_sys) disable iff (reset)
      (!ctrl_q.enable && !(wr_sum_l | wr_sum_h | wr_sum_u)) |=> $stable(sum_q))
      else $error("accumulator moved while disabled");

   chk_stop_out_rest: assert property (  // see RULE21
      @(posedge clk_sys) disable iff (reset)
      (!ctrl_q.enable && !$past(ctrl_q.enable)) |=> out_q == $past(ctrl_q.invert_select))
      else $error("output not at rest level while disabled");

   chk_level_shown: assert property (  // see RULE2
      @(posedge clk_sys) disable iff (reset)
      (bus_req.rd && bus_req.addr == pst_pkg::PST_ADDR_CONTROL)
      |=> rdata[pst_pkg::PST_CON_OUT] == $past(out_q))
      else $error("level bit does not match output");

   chk_invert_flip: assert property (  // see RULE3
      @(posedge clk_sys) disable iff (reset)
      ($changed(ctrl_q.invert_select) && $stable(ctrl_q.enable) && $stable(raw_out))
      |=> $changed(out_q))
      else $error("polarity change did not flip output");

   chk_sum_adds: assert property (  // see RULE17
      @(posedge clk_sys) disable iff (reset)
      (ctrl_q.enable && tick && !(wr_sum_l | wr_sum_h | wr_sum_u))
      |=> sum_q == $past(sum_wide[19:0]))
      else $error("accumulator did not add shadow step");

   chk_flag_sets: assert property (  // see RULE20
      @(posedge clk_sys) disable iff (reset)
      carry |=> flag_q ##1 (flag_q || $past(bus_req.wr)))
      else $error("overflow flag not set or lost");

   chk_fdc_toggle: assert property (  // see RULE18
      @(posedge clk_sys) disable iff (reset)
      (carry && !ctrl_q.pulse_mode_select) |=> toggle_q != $past(toggle_q))
      else $error("fixed duty toggle missed");

   chk_pulse_load: assert property (  // see RULE19
      @(posedge clk_sys) disable iff (reset)
      (ctrl_q.enable && tick && arm_q) |=> pcnt_q == $past(width_cnt))
      else $error("pulse width count wrong");

   chk_rsvd_no_tick: assert property (  // see RULE8
      @(posedge clk_sys) disable iff (reset)
      clksel_q.source_select == pst_pkg::PST_SRC_RSVD |-> !tick && !fall)
      else $error("reserved source produced an edge");

   chk_sum_top_zero: assert property (  // see RULE9
      @(posedge clk_sys) disable iff (reset)
      (bus_req.rd && bus_req.addr == pst_pkg::PST_ADDR_SUM_UPPER)
      |=> rdata[7:4] == 4'h0)
      else $error("reserved accumulator bits read nonzero");

   chk_shadow_stopped: assert property (  // see RULE15
      @(posedge clk_sys) disable iff (reset)
      (wr_step_l && !ctrl_q.enable && !(bus_req.wr &&
       bus_req.addr == pst_pkg::PST_ADDR_CONTROL))
      |=> ##1 shadow_q == $past(step_q))
      else $error("shadow not loaded while stopped");

   // an idle port must read as zero so a stray sample never looks like data
   chk_rdata_idle: assert property (
      @(posedge clk_sys) disable iff (reset)
      !bus_req.rd |=> rdata == pst_pkg::PST_BYTE_ZERO)
      else $error("read data present without a read strobe");

   chk_stop_clears: assert property (  // see RULE21
      @(posedge clk_sys) disable iff (reset)
      !ctrl_q.enable |=> !toggle_q && pcnt_q == pst_pkg::PST_BYTE_ZERO)
      else $error("toggle or pulse count kept while disabled");
endmodule

// *** hw/pst_pkg.sv ***
// Purpose: constants and carrier types for the phase stepper oscillator
// Assumes: 8-bit register port with 12-bit byte addresses
// Notes:   offsets are byte addresses on the plain register port
package pst_pkg;
   localparam int unsigned PST_AW     = 12;
   localparam int unsigned PST_DW     = 8;
   localparam int unsigned PST_SUM_W  = 20;
   localparam int unsigned PST_NSRC   = 14;
   localparam int unsigned PST_CNT_W  = 8;

   localparam logic [11:0] PST_ADDR_SUM_LOW   = 12'h58C;
   localparam logic [11:0] PST_ADDR_SUM_HIGH  = 12'h58D;
   localparam logic [11:0] PST_ADDR_SUM_UPPER = 12'h58E;
   localparam logic [11:0] PST_ADDR_STEP_LOW  = 12'h58F;
   localparam logic [11:0] PST_ADDR_STEP_HIGH = 12'h590;
   localparam logic [11:0] PST_ADDR_STEP_UPPER= 12'h591;
   localparam logic [11:0] PST_ADDR_CONTROL   = 12'h592;
   localparam logic [11:0] PST_ADDR_CLOCK     = 12'h593;
   localparam logic [11:0] PST_ADDR_FLAG      = 12'h594;

   localparam int unsigned PST_CON_EN   = 7;
   localparam int unsigned PST_CON_OUT  = 5;
   localparam int unsigned PST_CON_POL  = 4;
   localparam int unsigned PST_CON_PFM  = 0;
   localparam int unsigned PST_CLK_PWS_LO = 5;
   localparam int unsigned PST_CLK_CKS_LO = 0;
   localparam int unsigned PST_FLAG_BIT = 0;

   localparam logic [19:0] PST_STEP_RESET = 20'h00001;
   localparam logic [19:0] PST_SUM_RESET  = 20'h00000;
   localparam logic [3:0]  PST_SRC_SYS    = 4'h0;
   localparam logic [3:0]  PST_SRC_RSVD   = 4'hF;
   localparam logic [7:0]  PST_CNT_ONE    = 8'h01;
   localparam logic [7:0]  PST_BYTE_ZERO  = 8'h00;

   typedef struct packed {
      logic [11:0] addr;
      logic [7:0]  wdata;
      logic        wr;
      logic        rd;
   } pst_bus_req_t;

   typedef struct packed {
      logic enable;
      logic invert_select;
      logic pulse_mode_select;
   } pst_ctrl_t;

   typedef struct packed {
      logic [2:0] pulse_width_select;
      logic [3:0] source_select;
   } pst_clksel_t;

   typedef enum logic [0:0] {
      PST_LOAD_IDLE = 1'b0,
      PST_LOAD_WAIT = 1'b1
   } pst_load_state_t;
endpackage

// *** testbench/pst_src_model.sv ***
// Purpose: far-side clock sources feeding the phase stepper source inputs
// Assumes: one clk_sys domain; sources are synchronous levels
// Notes:   bits 0..12 run free, bit 13 stands low except in requested bursts
`timescale 1ns/10ps
module pst_src_model (
   input  wire logic        clk_sys,
   input  wire logic        reset,
   input  wire logic        kick,
   input  wire logic [7:0]  kick_n,
   output logic      [13:0] src_clk
);
   logic [4:0]  half_q [13];
   logic [12:0] free_q;
   logic [7:0]  left_q;
   logic [2:0]  ph_q;

   // bit k has a half period of k+2 cycles so each code gets its own rate
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         free_q <= '0;
         for (int k = 0; k < 13; k++) half_q[k] <= '0;
      end else begin
         for (int k = 0; k < 13; k++) begin
            if (half_q[k] == 5'(k + 1)) begin
               half_q[k] <= '0;
               free_q[k] <= ~free_q[k];
            end else begin
               half_q[k] <= half_q[k] + 5'h01;
            end
         end
      end
   end

   // burst source: exact edge counts let the bench predict the sum
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         left_q <= 8'h00;
         ph_q   <= 3'h0;
      end else if (kick) begin
         left_q <= kick_n;
         ph_q   <= 3'h0;
      end else if (left_q != 8'h00) begin
         ph_q <= ph_q + 3'h1;
         if (ph_q == 3'h7) left_q <= left_q - 8'h01;
      end
   end

   assign src_clk = {(left_q != 8'h00) && (ph_q < 3'h4), free_q};
endmodule

// *** testbench/tb_numerically_controlled_oscillator.sv ***
// Purpose: self-checking bench for the phase stepper through its register port
// Assumes: 200 MHz clk_sys; register port answers in the next cycle
// Notes:   output rates are judged by counting active cycles over whole periods
`timescale 1ns/10ps
module tb_numerically_controlled_oscillator;
   logic                          clk_sys;
   logic                          reset;
   pst_pkg::pst_bus_req_t         bus_req;
   logic [7:0]                    rdata;
   logic [pst_pkg::PST_NSRC-1:0]  src_clk;
   logic                          stepper_out;
   logic                          overflow_flag;
   logic                          kick;
   logic [7:0]                    kick_n;
   int                            n_errors;
   int                            n_tests;
   int                            per;
   logic [7:0]                    v0;
   logic [7:0]                    v1;
   logic [15:0]                   cnt;

   pst_phase_stepper i_dut (
      .clk_sys       (clk_sys),
      .reset         (reset),
      .bus_req       (bus_req),
      .rdata         (rdata),
      .src_clk       (src_clk),
      .stepper_out   (stepper_out),
      .overflow_flag (overflow_flag)
   );

   pst_src_model i_src (
      .clk_sys (clk_sys),
      .reset   (reset),
      .kick    (kick),
      .kick_n  (kick_n),
      .src_clk (src_clk)
   );

   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      n_tests++;
      if (seen !== exp) begin
         n_errors++;
         $display("wrong value at %0t: seen %0h expected %0h", $time, seen, exp);
      end
   endtask

   task automatic wr(input logic [11:0] a, input logic [7:0] d);
      @(posedge clk_sys);
      bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge clk_sys);
      bus_req.wr <= 1'b0;
   endtask

   task automatic rd(input logic [11:0] a, output logic [7:0] d);
      @(posedge clk_sys);
      bus_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
      @(posedge clk_sys);
      bus_req.rd <= 1'b0;
      #1;
      d = rdata;
   endtask

   task automatic rc(input logic [11:0] a, input logic [7:0] exp);
      logic [7:0] d;
      rd(a, d);
      chk(16'(d), 16'(exp));
   endtask

   // upper and high first so the shadow never catches half a value
   task automatic wstep(input logic [19:0] v);
      wr(pst_pkg::PST_ADDR_STEP_UPPER, {4'h0, v[19:16]});
      wr(pst_pkg::PST_ADDR_STEP_HIGH, v[15:8]);
      wr(pst_pkg::PST_ADDR_STEP_LOW, v[7:0]);
   endtask

   task automatic rsum(input logic [19:0] v);
      rc(pst_pkg::PST_ADDR_SUM_LOW, v[7:0]);
      rc(pst_pkg::PST_ADDR_SUM_HIGH, v[15:8]);
      rc(pst_pkg::PST_ADDR_SUM_UPPER, {4'h0, v[19:16]});
   endtask

   task automatic burst(input logic [7:0] n);
      @(posedge clk_sys);
      kick   <= 1'b1;
      kick_n <= n;
      @(posedge clk_sys);
      kick <= 1'b0;
      repeat (8 * int'(n) + 8) @(posedge clk_sys);
   endtask

   task automatic act_count(input int n, input logic act, output logic [15:0] c);
      c = 16'h0000;
      repeat (n) begin
         @(posedge clk_sys);
         if (stepper_out === act) c = c + 16'h0001;
      end
   endtask

   task automatic stop_test();
      $display("comparisons %0d, mismatches %0d", n_tests, n_errors);
      if (n_errors == 0 && n_tests > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   initial begin
      clk_sys = 1'b0;
      forever #2.5 clk_sys = ~clk_sys;
   end

   // a hang counts as a mismatch and still reaches the verdict
   initial begin
      repeat (20000) @(posedge clk_sys);
      n_errors++;
      stop_test();
   end

   initial begin
      reset    = 1'b1;
      bus_req  = '0;
      kick     = 1'b0;
      kick_n   = 8'h00;
      n_errors = 0;
      n_tests  = 0;
      repeat (16) @(posedge clk_sys);
      reset <= 1'b0;
      // 0x58C..0x594 mapped, 0x595 unmapped; only the step low byte resets to 1
      for (int i = 0; i < 10; i++) begin
         rc(12'h58C + 12'(i), (i == 3) ? 8'h01 : 8'h00);
      end
      $display("test reset values done");

      wr(pst_pkg::PST_ADDR_CLOCK, 8'hFF);
      rc(pst_pkg::PST_ADDR_CLOCK, 8'hEF);
      wr(pst_pkg::PST_ADDR_STEP_UPPER, 8'hFF);
      rc(pst_pkg::PST_ADDR_STEP_UPPER, 8'h0F);
      wr(pst_pkg::PST_ADDR_SUM_UPPER, 8'hFF);
      rc(pst_pkg::PST_ADDR_SUM_UPPER, 8'h0F);
      wr(pst_pkg::PST_ADDR_CONTROL, 8'h7F);
      rc(pst_pkg::PST_ADDR_CONTROL, 8'h31);
      chk(16'(stepper_out), 16'h0001);
      wr(12'h595, 8'hAA);
      rc(12'h595, 8'h00);
      $display("test register access done");

      // half-range step overflows every second tick: output period is 4 ticks
      wr(pst_pkg::PST_ADDR_CONTROL, 8'h00);
      wstep(20'h80000);
      for (int c = 0; c < 14; c++) begin
         per = (c == 0) ? 1 : 2 * c + 2;
         wr(pst_pkg::PST_ADDR_CLOCK, {3'b111, 1'b0, 4'(c)});
         wr(pst_pkg::PST_ADDR_CONTROL, 8'h80);
         repeat (8 * per) @(posedge clk_sys);
         act_count(8 * per, 1'b1, cnt);
         chk(cnt, 16'(4 * per));
         wr(pst_pkg::PST_ADDR_CONTROL, 8'h00);
      end
      chk(16'(overflow_flag), 16'h0001);
      rc(pst_pkg::PST_ADDR_FLAG, 8'h01);
      wr(pst_pkg::PST_ADDR_FLAG, 8'h01);
      rc(pst_pkg::PST_ADDR_FLAG, 8'h00);
      wr(pst_pkg::PST_ADDR_CLOCK, 8'h0F);
      wr(pst_pkg::PST_ADDR_CONTROL, 8'h80);
      repeat (20) @(posedge clk_sys);
      chk(16'(overflow_flag), 16'h0000);
      wr(pst_pkg::PST_ADDR_CONTROL, 8'h00);
      $display("test fixed duty and sources done");

      // 256 ticks between overflows leaves room for the widest pulse
      wstep(20'h01000);
      for (int k = 0; k < 8; k++) begin
         wr(pst_pkg::PST_ADDR_CLOCK, {3'(k), 5'h00});
         wr(pst_pkg::PST_ADDR_CONTROL, {3'b100, 1'(k), 3'b000, 1'b1});
         repeat (300) @(posedge clk_sys);
         act_count(256, ~1'(k), cnt);
         chk(cnt, 16'h0001 << k);
         wr(pst_pkg::PST_ADDR_CONTROL, {3'b000, 1'(k), 4'h0});
      end
      rc(pst_pkg::PST_ADDR_CONTROL, 8'h30);
      chk(16'(stepper_out), 16'h0001);
      rd(pst_pkg::PST_ADDR_SUM_HIGH, v0);
      repeat (20) @(posedge clk_sys);
      rd(pst_pkg::PST_ADDR_SUM_HIGH, v1);
      chk(16'(v1), 16'(v0));
      $display("test pulse mode done");

      wr(pst_pkg::PST_ADDR_CONTROL, 8'h00);
      wr(pst_pkg::PST_ADDR_SUM_UPPER, 8'h00);
      wr(pst_pkg::PST_ADDR_SUM_HIGH, 8'h00);
      wr(pst_pkg::PST_ADDR_SUM_LOW, 8'h00);
      wstep(20'h12345);
      wr(pst_pkg::PST_ADDR_CLOCK, 8'h0E);
      wr(pst_pkg::PST_ADDR_CONTROL, 8'h80);
      burst(8'h05);
      wr(pst_pkg::PST_ADDR_CONTROL, 8'h00);
      rsum(20'h5B059);
      // new step must wait for a falling source edge: first tick still adds the old one
      wr(pst_pkg::PST_ADDR_CONTROL, 8'h80);
      wstep(20'h00010);
      burst(8'h02);
      wr(pst_pkg::PST_ADDR_CONTROL, 8'h00);
      rsum(20'h6D3AE);
      $display("test accumulation done");
      stop_test();
   end
endmodule
